// ### logic/cis_sequencer.sv
// cpu interrupt and reset sequencer with avalon-mm register slave
// assumes the pipeline flags instruction boundaries with instr_done
// and holds while cpu_hold is high; one clock, clock enable ce
`timescale 1ns/100ps
module cis_sequencer #(
  parameter int              N_SRC      = 8,
  parameter logic [31:0]     LEVEL_MASK = 32'h0000_0000,
  parameter int              SP_W       = 8,
  parameter logic [23:0]     BOOT_START = 24'h00_f000,
  parameter logic [23:0]     VEC_STEP   = 24'h00_0002,
  parameter int              IDX_W      = 5
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [N_SRC-1:0]  src_flag_evt,
  input  wire logic [N_SRC-1:0]  src_level,
  input  wire logic              instr_done,
  input  wire logic              instr_is_return_from_irq_instr,
  input  wire logic              instr_is_sei,
  input  wire logic              instr_is_cli,
  input  wire logic              cpu_sleeping,
  input  wire logic [23:0]       pc_next,
  input  wire logic [23:0]       pc_cur,
  input  wire logic              boot_reset_fuse,
  input  wire logic              app_section_lock_bit,
  input  wire logic              boot_section_lock_bit,
  output logic                   cpu_hold,
  output logic                   pc_load,
  output logic      [23:0]       pc_load_addr,
  output logic      [N_SRC-1:0]  irq_ack,
  output logic                   glob_ie,
  output logic      [SP_W-1:0]   stack_ptr
);

  cis_pkg::cis_state_t st_q;
  cis_pkg::cis_state_t st_d;
  logic [2:0]       cnt_q;
  logic [2:0]       cnt_d;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rd_mux;
  logic             gie_q;
  logic             vsel_q;
  logic [N_SRC-1:0] ien_q;
  logic [N_SRC-1:0] flag_q;
  logic [N_SRC-1:0] pend;
  logic [N_SRC-1:0] req_en;
  logic [N_SRC-1:0] ack_q;
  logic [IDX_W-1:0] sel_idx;
  logic [IDX_W-1:0] act_idx_q;
  logic [23:0]      vec_q;
  logic [23:0]      vec_d;
  logic [23:0]      save_pc_q;
  logic [23:0]      ret_pc_q;
  logic [SP_W-1:0]  sp_q;
  logic             guard_q;
  logic             rst_done_q;
  logic             hold_q;
  logic             load_q;
  logic [23:0]      load_addr_q;
  logic             wr_acc;
  logic             cli_now;
  logic             sei_now;
  logic             return_from_irq_instr_now;
  logic             lock_sup;
  logic             allow;
  logic             take_run;
  logic             take_wake;
  logic             take;
  logic             entry_end;
  logic             ret_end;
  logic             push_we;
  logic [7:0]       push_byte;
  logic [SP_W-1:0]  pop_addr;
  logic [7:0]       pop_byte;

  ////////////////////////////////////////////////////////////////////////
  // register bus: one wait cycle, then the access takes effect

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 1'b1;
    end else if (ce) begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  assign wr_acc = avs_write && !wait_q;

  always_comb begin
    rd_mux = '0;
    case (avs_address)
      cis_pkg::OFS_FLAGS:  rd_mux[cis_pkg::GIE_BIT] = gie_q;
      cis_pkg::OFS_MCU:    rd_mux[cis_pkg::VSEL_BIT] = vsel_q;
      cis_pkg::OFS_IEN:    rd_mux[N_SRC-1:0] = ien_q;
      cis_pkg::OFS_IFLAG:  rd_mux[N_SRC-1:0] = flag_q;
      cis_pkg::OFS_STACK:  rd_mux[SP_W-1:0] = sp_q;
      cis_pkg::OFS_STATUS: begin
        rd_mux[cis_pkg::ST_LSB +: 5] = st_q;
        rd_mux[cis_pkg::GRD_BIT] = guard_q;
        rd_mux[cis_pkg::IDX_LSB +: IDX_W] = act_idx_q;
      end
      default: rd_mux = '0;
    endcase
  end

  // read data is loaded as waitrequest drops and stands at that edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce && avs_read && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      vsel_q <= cis_pkg::VSEL_RST;
      ien_q  <= '0;
    end else if (ce && wr_acc) begin
      if (avs_address == cis_pkg::OFS_MCU) begin
        vsel_q <= avs_writedata[cis_pkg::VSEL_BIT];
      end
      if (avs_address == cis_pkg::OFS_IEN) begin
        ien_q <= avs_writedata[N_SRC-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sources: flag type latches events, level type follows its input

  for (genvar g = 0; g < N_SRC; g++) begin : g_src
    logic w1c;
    assign w1c = wr_acc && (avs_address == cis_pkg::OFS_IFLAG) &&
                 avs_writedata[g];
    // an event in the clearing cycle wins over both clears
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        flag_q[g] <= 1'b0;
      end else if (ce) begin
        if (LEVEL_MASK[g]) begin
          flag_q[g] <= 1'b0;
        end else if (src_flag_evt[g]) begin
          flag_q[g] <= 1'b1;
        end else if (take && sel_idx == IDX_W'(g)) begin
          flag_q[g] <= 1'b0;
        end else if (w1c) begin
          flag_q[g] <= 1'b0;
        end
      end
    end
    assign pend[g] = LEVEL_MASK[g] ? src_level[g] : flag_q[g];
  end

  assign req_en = pend & ien_q;

  // lowest index means lowest vector, so it wins
  always_comb begin
    sel_idx = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (req_en[i]) begin
        sel_idx = IDX_W'(i);
      end
    end
  end

  // slot zero is reset, sources follow from slot one on
  always_comb begin
    vec_d = (vsel_q ? BOOT_START : 24'h00_0000) +
            24'(VEC_STEP * (24'(sel_idx) + 24'h00_0001));
  end

  ////////////////////////////////////////////////////////////////////////
  // take decision

  assign cli_now  = instr_done && instr_is_cli;
  assign sei_now  = instr_done && instr_is_sei;
  assign return_from_irq_instr_now = instr_done && instr_is_return_from_irq_instr;

  // simple protection model: the lock of the section being run applies
  assign lock_sup = (pc_cur >= BOOT_START) ? boot_section_lock_bit
                                           : app_section_lock_bit;

  // gie_q alone gates nesting, so a handler that sets it can be preempted
  assign allow = gie_q && !guard_q && !lock_sup && (|req_en) &&
                 rst_done_q && (st_q == cis_pkg::ST_RUN);

  assign take_run = allow && instr_done && !cpu_sleeping && !cli_now &&
                    !instr_is_return_from_irq_instr;
  assign take_wake = allow && cpu_sleeping;
  assign take      = take_run || take_wake;

  assign entry_end = (st_q == cis_pkg::ST_ENTRY) &&
                     (cnt_q == cis_pkg::ENTRY_CYC - 3'h1);
  assign ret_end   = (st_q == cis_pkg::ST_RET) &&
                     (cnt_q == cis_pkg::RET_CYC - 3'h1);

  ////////////////////////////////////////////////////////////////////////
  // sequence state

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q + 3'h1;
    case (st_q)
      cis_pkg::ST_RUN: begin
        cnt_d = 3'h0;
        if (take_wake) begin
          st_d = cis_pkg::ST_WAKE;
        end else if (take_run) begin
          st_d = cis_pkg::ST_ENTRY;
        end else if (return_from_irq_instr_now) begin
          st_d = cis_pkg::ST_RET;
        end
      end
      cis_pkg::ST_WAKE: begin
        if (cnt_q == cis_pkg::WAKE_CYC - 3'h1) begin
          st_d  = cis_pkg::ST_ENTRY;
          cnt_d = 3'h0;
        end
      end
      cis_pkg::ST_ENTRY: begin
        if (entry_end) begin
          st_d  = cis_pkg::ST_JUMP;
          cnt_d = 3'h0;
        end
      end
      cis_pkg::ST_JUMP: begin
        if (cnt_q == cis_pkg::JUMP_CYC - 3'h1) begin
          st_d = cis_pkg::ST_RUN;
        end
      end
      cis_pkg::ST_RET: begin
        if (ret_end) begin
          st_d = cis_pkg::ST_RUN;
        end
      end
      default: begin
        st_d  = cis_pkg::ST_RUN;
        cnt_d = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q  <= cis_pkg::ST_RUN;
      cnt_q <= 3'h0;
    end else if (ce) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // pipeline stays held until the reset vector is out and during sequences
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hold_q <= 1'b1;
    end else if (ce) begin
      hold_q <= (st_d != cis_pkg::ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // global enable; the flags register is never stacked

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gie_q <= cis_pkg::GIE_RST;
    end else if (ce) begin
      if (take) begin
        gie_q <= 1'b0;
      end else if (ret_end) begin
        gie_q <= 1'b1;
      end else if (cli_now) begin
        gie_q <= 1'b0;
      end else if (sei_now) begin
        gie_q <= 1'b1;
      end else if (wr_acc && avs_address == cis_pkg::OFS_FLAGS) begin
        gie_q <= avs_writedata[cis_pkg::GIE_BIT];
      end
    end
  end

  // one instruction must complete after return or an sei instruction
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      guard_q <= 1'b0;
    end else if (ce) begin
      if (ret_end) begin
        guard_q <= 1'b1;
      end else if (sei_now) begin
        guard_q <= 1'b1;
      end else if (instr_done) begin
        guard_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // captured request

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      vec_q     <= 24'h00_0000;
      act_idx_q <= '0;
      save_pc_q <= 24'h00_0000;
      ack_q     <= '0;
    end else if (ce) begin
      ack_q <= '0;
      if (take) begin
        vec_q     <= vec_d;
        act_idx_q <= sel_idx;
        save_pc_q <= pc_next;
        ack_q     <= N_SRC'(1) << sel_idx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stack: pushes low byte first, pops high byte first

  assign push_we   = (st_q == cis_pkg::ST_ENTRY) &&
                     (cnt_q < cis_pkg::PC_BYTES);
  assign push_byte = 8'(save_pc_q >> {cnt_q[1:0], 3'h0});
  assign pop_addr  = sp_q + SP_W'(cnt_q) + SP_W'(1);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sp_q <= '1;
    end else if (ce) begin
      if (push_we) begin
        sp_q <= sp_q - SP_W'(1);
      end else if (ret_end) begin
        sp_q <= sp_q + SP_W'(cis_pkg::PC_BYTES);
      end else if (wr_acc && avs_address == cis_pkg::OFS_STACK) begin
        sp_q <= avs_writedata[SP_W-1:0];
      end
    end
  end

  // popped bytes land one cycle after their address
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ret_pc_q <= 24'h00_0000;
    end else if (ce && st_q == cis_pkg::ST_RET) begin
      case (cnt_q)
        3'h1:    ret_pc_q[23:16] <= pop_byte;
        3'h2:    ret_pc_q[15:8]  <= pop_byte;
        3'h3:    ret_pc_q[7:0]   <= pop_byte;
        default: ret_pc_q <= ret_pc_q;
      endcase
    end
  end

  cis_stack_ram #(
    .AW (SP_W)
  ) u_stack (
    .clk_sys (clk_sys),
    .ce      (ce),
    .we      (push_we),
    .waddr   (sp_q),
    .wdata   (push_byte),
    .raddr   (pop_addr),
    .rdata_q (pop_byte)
  );

  ////////////////////////////////////////////////////////////////////////
  // program counter loads: reset vector, source vector, return address

  // the fuse is sampled at the first enabled edge after release
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_done_q  <= 1'b0;
      load_q      <= 1'b0;
      load_addr_q <= 24'h00_0000;
    end else if (ce) begin
      load_q <= 1'b0;
      if (!rst_done_q) begin
        rst_done_q  <= 1'b1;
        load_q      <= 1'b1;
        load_addr_q <= boot_reset_fuse ? BOOT_START
                                       : 24'h00_0000;
      end else if (entry_end) begin
        load_q      <= 1'b1;
        load_addr_q <= vec_q;
      end else if (ret_end) begin
        load_q      <= 1'b1;
        load_addr_q <= ret_pc_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign cpu_hold        = hold_q;
  assign pc_load         = load_q;
  assign pc_load_addr    = load_addr_q;
  assign irq_ack         = ack_q;
  assign glob_ie         = gie_q;
  assign stack_ptr       = sp_q;

endmodule

// ### logic/cis_pkg.sv
// constants shared by the interrupt sequencer and its testbench
// assumes a 100 MHz cpu clock and a 32-bit avalon-mm register bus
package cis_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_FLAGS  = 8'h00;
  localparam logic [7:0] OFS_MCU    = 8'h04;
  localparam logic [7:0] OFS_IEN    = 8'h08;
  localparam logic [7:0] OFS_IFLAG  = 8'h0c;
  localparam logic [7:0] OFS_STACK  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // field positions
  localparam int GIE_BIT  = 7;
  localparam int VSEL_BIT = 0;
  localparam int ST_LSB   = 0;
  localparam int GRD_BIT  = 8;
  localparam int IDX_LSB  = 16;

  // reset values
  localparam logic       GIE_RST  = 1'b0;
  localparam logic       VSEL_RST = 1'b0;

  // timing: clock period in ns, sequence lengths in cpu clock cycles
  localparam int CLK_NS = 10;
  localparam logic [2:0] ENTRY_CYC = 3'h5;
  localparam logic [2:0] WAKE_CYC  = 3'h5;
  localparam logic [2:0] JUMP_CYC  = 3'h3;
  localparam logic [2:0] RET_CYC   = 3'h5;
  localparam logic [2:0] PC_BYTES  = 3'h3;

  // program address width: three stacked bytes
  localparam int PC_W = 24;

  typedef enum logic [4:0] {
    ST_RUN   = 5'h01,
    ST_WAKE  = 5'h02,
    ST_ENTRY = 5'h04,
    ST_JUMP  = 5'h08,
    ST_RET   = 5'h10
  } cis_state_t;

endpackage

// ### logic/cis_stack_ram.sv
// byte-wide return-address stack memory, registered read data
// assumes one write port and one read port on the same clock
`timescale 1ns/100ps
module cis_stack_ram #(
  parameter int AW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata_q
);

  logic [7:0] mem [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////
  // no reset on the array: contents are undefined until pushed
  always_ff @(posedge clk_sys) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      rdata_q <= mem[raddr];
    end
  end

endmodule

// ### dv/cis_seq_monitor.sv
// checker: cpu-side timing of the interrupt sequencer
// assumes it is bound onto cis_sequencer, one clock domain
`timescale 1ns/100ps
module cis_seq_monitor #(
  parameter int N_SRC = 8,
  parameter int SP_W  = 8
) (
  input wire logic             clk_sys,
  input wire logic             nrst,
  input wire logic             instr_done,
  input wire logic             instr_is_return_from_irq_instr,
  input wire logic             instr_is_cli,
  input wire logic             cpu_sleeping,
  input wire logic             cpu_hold,
  input wire logic             pc_load,
  input wire logic [N_SRC-1:0] irq_ack,
  input wire logic             glob_ie,
  input wire logic [SP_W-1:0]  stack_ptr
);
  logic take_w;
  logic ret_w;
  logic bnd_w;
  assign take_w = |irq_ack;
  assign ret_w  = instr_done && instr_is_return_from_irq_instr && !cpu_hold;
  assign bnd_w  = instr_done || cpu_sleeping;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  a_needs_gie: assert property (take_w |-> $past(glob_ie))
    else $error("take without global enable");
  a_entry_gie: assert property (take_w |-> !glob_ie)
    else $error("global enable kept on entry");
  a_take_boundary: assert property (take_w |-> $past(bnd_w))
    else $error("take off an instruction boundary");
  a_entry_time: assert property (
    take_w && !cpu_sleeping |->
    (cpu_hold && !pc_load)[*5] ##1 (pc_load && cpu_hold))
    else $error("entry length wrong");
  a_wake_time: assert property (
    take_w && cpu_sleeping |-> ##10 (pc_load && cpu_hold))
    else $error("wake entry length wrong");
  a_jump_time: assert property (
    pc_load && cpu_hold |=> cpu_hold[*2] ##1 !cpu_hold)
    else $error("jump length wrong");
  a_push_sp: assert property (
    take_w && !cpu_sleeping |->
    ##3 (stack_ptr == $past(stack_ptr, 3) - SP_W'(3)))
    else $error("push did not lower pointer by three");
  a_wake_push: assert property (
    take_w && cpu_sleeping |->
    ##8 (stack_ptr == $past(stack_ptr, 8) - SP_W'(3)))
    else $error("wake push did not lower pointer by three");
  a_ret_time: assert property (
    ret_w |=> (cpu_hold && !pc_load)[*5] ##1
    (pc_load && !cpu_hold && glob_ie))
    else $error("return length wrong");
  a_ret_pop: assert property (
    ret_w |-> ##6 (stack_ptr == $past(stack_ptr, 6) + SP_W'(3)))
    else $error("pop did not raise pointer by three");
  a_clear_blocks: assert property (
    instr_done && instr_is_cli && !cpu_hold |=> !take_w && !glob_ie)
    else $error("take after global clear");
  c_entry: cover property (take_w && !cpu_sleeping);
  c_wake: cover property (take_w && cpu_sleeping);
  c_return: cover property (ret_w);
endmodule

bind cis_sequencer cis_seq_monitor #(.N_SRC(N_SRC), .SP_W(SP_W)) u_mon (
  .clk_sys, .nrst, .instr_done, .instr_is_return_from_irq_instr, .instr_is_cli,
  .cpu_sleeping, .cpu_hold, .pc_load, .irq_ack, .glob_ie, .stack_ptr
);

// ### dv/cis_cpu_model.sv
// pipeline model: one instruction per go request, redirected by pc_load
// assumes the sequencer stalls it with cpu_hold
`timescale 1ns/100ps
module cis_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic [1:0]  kind,
  input  wire logic        cpu_hold,
  input  wire logic        pc_load,
  input  wire logic [23:0] pc_load_addr,
  output logic             instr_done,
  output logic             instr_is_return_from_irq_instr,
  output logic             instr_is_sei,
  output logic             instr_is_cli,
  output logic      [23:0] pc_next,
  output logic      [23:0] pc_cur
);
  logic [23:0] pc_q;
  // no completion while stalled or while a new pc is loaded
  assign instr_done    = go && !cpu_hold && !pc_load;
  assign instr_is_return_from_irq_instr = instr_done && kind == 2'h1;
  assign instr_is_sei  = instr_done && kind == 2'h2;
  assign instr_is_cli  = instr_done && kind == 2'h3;
  // idle core: the next unexecuted address is the current one
  assign pc_next       = instr_done ? pc_q + 24'h00_0001 : pc_q;
  assign pc_cur        = pc_q;
  // flags are left to handler code, never saved here
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pc_q <= 24'h00_0000;
    end else if (pc_load) begin
      pc_q <= pc_load_addr;
    end else if (instr_done) begin
      pc_q <= pc_next;
    end
  end
endmodule

// ### dv/cis_sequencer_test.sv
// testbench: bus, pipeline and source stimulus for the sequencer
// assumes the pipeline model and a vector spacing of two
`timescale 1ns/100ps
module cis_sequencer_test;
  logic        clk_sys, avs_waitrequest, instr_done, cpu_hold, pc_load;
  logic        instr_is_return_from_irq_instr, instr_is_sei, instr_is_cli, glob_ie;
  logic        nrst = 1'b0, go = 1'b0, cpu_sleeping = 1'b0, ce = 1'b1;
  logic        boot_reset_fuse = 1'b0, app_section_lock_bit = 1'b0;
  logic        boot_section_lock_bit = 1'b0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [7:0]  avs_address = 8'h00, src_flag_evt = 8'h00;
  logic [7:0]  src_level = 8'h00, irq_ack, stack_ptr, ack_seen;
  logic [23:0] pc_next, pc_cur, pc_load_addr, addr;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
  logic [23:0] ret_q[$];
  int          failures = 0, total_checks = 0, n;

  cis_sequencer #(.LEVEL_MASK(32'h0000_0080)) uut (
    .clk_sys, .nrst, .ce, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .src_flag_evt,
    .src_level, .instr_done, .instr_is_return_from_irq_instr, .instr_is_sei, .instr_is_cli,
    .cpu_sleeping, .pc_next, .pc_cur, .boot_reset_fuse,
    .app_section_lock_bit, .boot_section_lock_bit, .cpu_hold,
    .pc_load, .pc_load_addr, .irq_ack, .glob_ie, .stack_ptr
  );
  cis_cpu_model pipe (
    .clk_sys, .nrst, .go, .kind, .cpu_hold, .pc_load, .pc_load_addr,
    .instr_done, .instr_is_return_from_irq_instr, .instr_is_sei, .instr_is_cli, .pc_next,
    .pc_cur
  );
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic pulse(input logic [7:0] m);
    src_flag_evt <= m;
    @(posedge clk_sys);
    src_flag_evt <= 8'h00;
  endtask
  // one instruction; ack_seen holds the source taken at its boundary
  task automatic issue(input logic [1:0] k);
    kind <= k;
    go <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (instr_done !== 1'b1 && n < 50);
    if (instr_done !== 1'b1) failures++;
    go <= 1'b0;
    kind <= 2'h0;
    @(posedge clk_sys);
    ack_seen = irq_ack;
    if (ack_seen !== 8'h00) ret_q.push_back(pc_cur);
  endtask
  task automatic measure(input int c, input logic [23:0] v);
    n = 0;
    // no stale address may pass when no load pulse comes
    addr = 24'hff_ffff;
    while (cpu_hold === 1'b1 && n < 40) begin
      n++;
      @(posedge clk_sys);
      if (pc_load === 1'b1) addr = pc_load_addr;
    end
    chk(32'(n), 32'(c));
    chk(32'(addr), 32'(v));
  endtask
  task automatic idle(input logic [1:0] k);
    issue(k);
    chk(32'(ack_seen), 32'h0);
  endtask
  task automatic enter(input logic [7:0] a, input logic [23:0] v);
    issue(2'h0);
    chk(32'(ack_seen), 32'(a));
    measure(8, v);
  endtask
  task automatic back;
    issue(2'h1);
    measure(5, ret_q.pop_back());
  endtask
  task automatic boot(input logic [23:0] v);
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pc_load !== 1'b1 && n < 50);
    if (pc_load !== 1'b1) failures++;
    chk(32'(pc_load_addr), 32'(v));
  endtask
  ////////////////////////////////////////
  initial begin
    boot(24'h00_0000);
    rd(cis_pkg::OFS_FLAGS, 32'h0);
    rd(8'h40, 32'h0);
    pulse(8'h2d);
    rd(cis_pkg::OFS_IFLAG, 32'h2d);
    wr(cis_pkg::OFS_IFLAG, 32'h0);
    rd(cis_pkg::OFS_IFLAG, 32'h2d);
    wr(cis_pkg::OFS_IFLAG, 32'h08);
    rd(cis_pkg::OFS_IFLAG, 32'h25);
    ce <= 1'b0;
    pulse(8'h10);
    ce <= 1'b1;
    rd(cis_pkg::OFS_IFLAG, 32'h25);
    wr(cis_pkg::OFS_IEN, 32'h7f);
    idle(2'h0);
    wr(cis_pkg::OFS_FLAGS, 32'h80);
    idle(2'h3);
    chk(32'(glob_ie), 32'h0);
    wr(cis_pkg::OFS_FLAGS, 32'h80);
    enter(8'h01, 24'h00_0002);
    chk(32'(glob_ie), 32'h0);
    rd(cis_pkg::OFS_IFLAG, 32'h24);
    wr(cis_pkg::OFS_FLAGS, 32'h80);
    enter(8'h04, 24'h00_0006);
    chk(32'(stack_ptr), 32'hf9);
    rd(cis_pkg::OFS_STATUS, 32'h0002_0001);
    back();
    chk(32'(glob_ie), 32'h1);
    idle(2'h0);
    enter(8'h20, 24'h00_000c);
    back();
    back();
    chk(32'(stack_ptr), 32'hff);
    wr(cis_pkg::OFS_FLAGS, 32'h0);
    wr(cis_pkg::OFS_MCU, 32'h1);
    pulse(8'h02);
    idle(2'h2);
    idle(2'h0);
    enter(8'h02, 24'h00_f004);
    back();
    app_section_lock_bit <= 1'b1;
    pulse(8'h02);
    idle(2'h0);
    idle(2'h0);
    app_section_lock_bit <= 1'b0;
    enter(8'h02, 24'h00_f004);
    boot_section_lock_bit <= 1'b1;
    wr(cis_pkg::OFS_FLAGS, 32'h80);
    pulse(8'h04);
    idle(2'h0);
    boot_section_lock_bit <= 1'b0;
    wr(cis_pkg::OFS_FLAGS, 32'h0);
    wr(cis_pkg::OFS_IFLAG, 32'h04);
    back();
    idle(2'h0);
    src_level <= 8'h80;
    @(posedge clk_sys);
    src_level <= 8'h00;
    wr(cis_pkg::OFS_IEN, 32'hff);
    idle(2'h0);
    src_level <= 8'h80;
    enter(8'h80, 24'h00_f010);
    src_level <= 8'h00;
    back();
    idle(2'h0);
    cpu_sleeping <= 1'b1;
    pulse(8'h02);
    n = 0;
    while (irq_ack === 8'h00 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    ret_q.push_back(pc_cur);
    cpu_sleeping <= 1'b0;
    chk(32'(irq_ack), 32'h02);
    measure(13, 24'h00_f004);
    back();
    nrst <= 1'b0;
    boot_reset_fuse <= 1'b1;
    boot(24'h00_f000);
    print_verdict();
  end
endmodule
